// [logic/tmr_timer.sv]
// 16-bit timer/counter: normal, clear-on-match and fast pwm modes, two compare channels
// assumes a synchronous apb master on SYS_CLK, with flags cleared by software or through FLAG_ACK
`include "tmr_defines.svh"

module tmr_timer
   import tmr_pkg::*;
#(
   parameter int PRESCALE_W = `TMR_PRESCALE_W
)(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [`TMR_ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [3:0] FLAG_ACK,
   output logic OC_A_OUT,
   output logic OC_A_OE_N,
   output logic OC_B_OUT,
   output logic OC_B_OE_N
);

   // ****************************************
   // decoding helpers
   // ****************************************
   function automatic logic is_fast_pwm(input logic [3:0] mode);
      is_fast_pwm = (mode == `TMR_WGM_FPWM8) || (mode == `TMR_WGM_FPWM9) ||
                    (mode == `TMR_WGM_FPWM10) || (mode == `TMR_WGM_FPWM_CAP) ||
                    (mode == `TMR_WGM_FPWM_A);
   endfunction

   // bits a compare write may keep; fixed tops mask the rest to zero
   function automatic logic [15:0] fixed_mask(input logic [3:0] mode);
      case (mode)
         `TMR_WGM_FPWM8: fixed_mask = `TMR_TOP_8;
         `TMR_WGM_FPWM9: fixed_mask = `TMR_TOP_9;
         `TMR_WGM_FPWM10: fixed_mask = `TMR_TOP_10;
         default: fixed_mask = `TMR_MAX;
      endcase
   endfunction

   function automatic logic prescale_hit(input logic [2:0] sel,
                                         input logic [PRESCALE_W-1:0] cnt);
      case (sel)
         `TMR_CS_DIV1: prescale_hit = 1'b1;
         `TMR_CS_DIV8: prescale_hit = &cnt[`TMR_DIV8_BITS-1:0];
         `TMR_CS_DIV64: prescale_hit = &cnt[`TMR_DIV64_BITS-1:0];
         `TMR_CS_DIV256: prescale_hit = &cnt[`TMR_DIV256_BITS-1:0];
         `TMR_CS_DIV1024: prescale_hit = &cnt[`TMR_DIV1024_BITS-1:0];
         default: prescale_hit = 1'b0;
      endcase
   endfunction

   // next output state on a match or at top; channel a alone may toggle in pwm
   function automatic logic oc_step(input logic oc, input logic [1:0] act, input logic pwm,
                                    input logic may_toggle, input logic hit,
                                    input logic top);
      oc_step = oc;
      if (!pwm) begin
         if (hit) begin
            case (act)
               `TMR_ACT_TOGGLE: oc_step = ~oc;
               `TMR_ACT_CLEAR: oc_step = 1'b0;
               `TMR_ACT_SET: oc_step = 1'b1;
               default: oc_step = oc;
            endcase
         end
      end else if (hit) begin
         case (act)
            `TMR_ACT_TOGGLE: oc_step = may_toggle ? ~oc : oc;
            `TMR_ACT_CLEAR: oc_step = 1'b1;
            `TMR_ACT_SET: oc_step = 1'b0;
            default: oc_step = oc;
         endcase
      end else if (top) begin
         case (act)
            `TMR_ACT_CLEAR: oc_step = 1'b0;
            `TMR_ACT_SET: oc_step = 1'b1;
            default: oc_step = oc;
         endcase
      end
   endfunction

   // ****************************************
   // state
   // ****************************************
   tmr_ctrl_s ctrl, next_ctrl;
   tmr_flags_s flags, next_flags;
   logic [PRESCALE_W-1:0] prescale, next_prescale;
   logic [15:0] count, next_count;
   logic [15:0] cmp_a_buf, next_cmp_a_buf;
   logic [15:0] cmp_a_act, next_cmp_a_act;
   logic [15:0] cmp_b, next_cmp_b;
   logic [15:0] cap_top, next_cap_top;
   logic oc_a, next_oc_a;
   logic oc_b, next_oc_b;
   logic block_match, next_block_match;
   logic [31:0] prdata, next_prdata;
   logic pslverr, next_pslverr;

   // ****************************************
   // decode of mode, top and bus
   // ****************************************
   logic tick;
   logic pwm;
   logic top_clears;
   logic [15:0] top;
   logic at_top;
   logic match_a;
   logic match_b;
   logic force_a;
   logic force_b;
   logic wr;
   logic setup;
   logic mapped;
   logic [15:0] wmask;

   always_comb begin
      tick = prescale_hit(ctrl.clock_select, prescale);
      pwm = is_fast_pwm(ctrl.waveform_mode_select);
      case (ctrl.waveform_mode_select)
         `TMR_WGM_CTC_A, `TMR_WGM_FPWM_A: top = cmp_a_act;
         `TMR_WGM_CTC_CAP, `TMR_WGM_FPWM_CAP: top = cap_top;
         `TMR_WGM_FPWM8: top = `TMR_TOP_8;
         `TMR_WGM_FPWM9: top = `TMR_TOP_9;
         `TMR_WGM_FPWM10: top = `TMR_TOP_10;
         default: top = `TMR_MAX;
      endcase
      top_clears = pwm || (ctrl.waveform_mode_select == `TMR_WGM_CTC_A) ||
                   (ctrl.waveform_mode_select == `TMR_WGM_CTC_CAP);
      // a counter write hides every match, top included, for one timer cycle
      at_top = tick && top_clears && (count == top) && !block_match;
      match_a = tick && (count == cmp_a_act) && !block_match;
      match_b = tick && (count == cmp_b) && !block_match;
      wr = PSEL && PENABLE && PWRITE;
      setup = PSEL && !PENABLE;
      mapped = (PADDR == `TMR_REG_CTRL) || (PADDR == `TMR_REG_FORCE) ||
               (PADDR == `TMR_REG_COUNT) || (PADDR == `TMR_REG_CMPA) ||
               (PADDR == `TMR_REG_CMPB) || (PADDR == `TMR_REG_CAPTOP) ||
               (PADDR == `TMR_REG_FLAGS);
      force_a = wr && (PADDR == `TMR_REG_FORCE) && PWDATA[`TMR_FORCE_A] && !pwm;
      force_b = wr && (PADDR == `TMR_REG_FORCE) && PWDATA[`TMR_FORCE_B] && !pwm;
      wmask = fixed_mask(ctrl.waveform_mode_select);
   end

   // ****************************************
   // counter, compare registers and outputs
   // ****************************************
   always_comb begin
      next_prescale = prescale + 1'b1;
      next_ctrl = ctrl;
      next_count = count;
      next_cmp_a_buf = cmp_a_buf;
      next_cmp_a_act = cmp_a_act;
      next_cmp_b = cmp_b;
      next_cap_top = cap_top;
      next_block_match = block_match;
      if (tick) begin
         next_block_match = 1'b0;
         if (at_top) begin
            next_count = `TMR_BOTTOM;
         end else begin
            next_count = count + `TMR_ONE;
         end
         if (pwm && at_top) begin
            next_cmp_a_act = cmp_a_buf;
         end
      end
      // the action field is sampled when a match or force fires, and at top in fast pwm
      next_oc_a = oc_step(oc_a, ctrl.compare_a_output_action, pwm,
                          ctrl.waveform_mode_select == `TMR_WGM_FPWM_A,
                          match_a || force_a, pwm && at_top);
      next_oc_b = oc_step(oc_b, ctrl.compare_b_output_action, pwm, 1'b0,
                          match_b || force_b, pwm && at_top);
      if (wr) begin
         case (PADDR)
            `TMR_REG_CTRL: begin
               next_ctrl = tmr_ctrl_s'(PWDATA);
               next_ctrl.rsvd = '0;
            end
            `TMR_REG_COUNT: begin
               next_count = PWDATA[15:0];
               next_block_match = 1'b1;
            end
            `TMR_REG_CMPA: begin
               next_cmp_a_buf = PWDATA[15:0] & wmask;
               if (!pwm) begin
                  next_cmp_a_act = PWDATA[15:0] & wmask;
               end
            end
            `TMR_REG_CMPB: next_cmp_b = PWDATA[15:0] & wmask;
            `TMR_REG_CAPTOP: next_cap_top = PWDATA[15:0];
            default: next_cap_top = cap_top;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         prescale <= '0;
         ctrl <= tmr_ctrl_s'(`TMR_RST_WORD);
         count <= `TMR_RST_16;
         cmp_a_buf <= `TMR_RST_16;
         cmp_a_act <= `TMR_RST_16;
         cmp_b <= `TMR_RST_16;
         cap_top <= `TMR_RST_16;
         oc_a <= 1'b0;
         oc_b <= 1'b0;
         block_match <= 1'b0;
      end else begin
         prescale <= next_prescale;
         ctrl <= next_ctrl;
         count <= next_count;
         cmp_a_buf <= next_cmp_a_buf;
         cmp_a_act <= next_cmp_a_act;
         cmp_b <= next_cmp_b;
         cap_top <= next_cap_top;
         oc_a <= next_oc_a;
         oc_b <= next_oc_b;
         block_match <= next_block_match;
      end
   end

   // ****************************************
   // sticky flags: a set in the clearing cycle wins
   // ****************************************
   tmr_flags_s flag_set;
   tmr_flags_s flag_clr;

   always_comb begin
      flag_set.overflow_flag = pwm ? at_top : (tick && count == `TMR_MAX);
      flag_set.compare_a_flag = match_a;
      flag_set.compare_b_flag = match_b;
      flag_set.capture_flag = at_top &&
                              ((ctrl.waveform_mode_select == `TMR_WGM_CTC_CAP) ||
                               (ctrl.waveform_mode_select == `TMR_WGM_FPWM_CAP));
      flag_clr = tmr_flags_s'(FLAG_ACK);
      if (wr && PADDR == `TMR_REG_FLAGS) begin
         flag_clr = flag_clr | tmr_flags_s'(PWDATA[3:0]);
      end
      next_flags = (flags & ~flag_clr) | flag_set;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         flags <= tmr_flags_s'(`TMR_RST_FLAGS);
      end else begin
         flags <= next_flags;
      end
   end

   // ****************************************
   // apb read path: data is latched in setup so access has zero wait
   // ****************************************
   always_comb begin
      next_prdata = prdata;
      next_pslverr = pslverr;
      if (setup) begin
         next_pslverr = !mapped;
         case (PADDR)
            `TMR_REG_CTRL: next_prdata = 32'(ctrl);
            `TMR_REG_COUNT: next_prdata = {16'h0000, count};
            `TMR_REG_CMPA: next_prdata = {16'h0000, cmp_a_buf};
            `TMR_REG_CMPB: next_prdata = {16'h0000, cmp_b};
            `TMR_REG_CAPTOP: next_prdata = {16'h0000, cap_top};
            `TMR_REG_FLAGS: next_prdata = {28'h0000000, flags};
            default: next_prdata = `TMR_RST_WORD;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         prdata <= `TMR_RST_WORD;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   assign PRDATA = prdata;
   assign PSLVERR = pslverr && PSEL && PENABLE;
   assign PREADY = 1'b1;
   // pin override only while an action is selected; direction drives the enable
   assign OC_A_OUT = oc_a && (ctrl.compare_a_output_action != `TMR_ACT_NONE);
   assign OC_B_OUT = oc_b && (ctrl.compare_b_output_action != `TMR_ACT_NONE);
   assign OC_A_OE_N = !ctrl.compare_a_pin_direction;
   assign OC_B_OE_N = !ctrl.compare_b_pin_direction;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   logic cnt_wr;
   assign cnt_wr = wr && (PADDR == `TMR_REG_COUNT);

   normal_wrap_a: assert property (
      (tick && ctrl.waveform_mode_select == `TMR_WGM_NORMAL && count == `TMR_MAX && !cnt_wr)
      |=> (count == `TMR_BOTTOM))
      else $error("normal mode did not wrap to zero");

   normal_ovf_a: assert property (
      (tick && ctrl.waveform_mode_select == `TMR_WGM_NORMAL && count == `TMR_MAX)
      |=> (count == `TMR_BOTTOM || $past(cnt_wr)) && flags.overflow_flag)
      else $error("overflow flag missing at wrap");

   ctc_clear_a: assert property (
      (tick && ctrl.waveform_mode_select == `TMR_WGM_CTC_A && count == cmp_a_act &&
       !block_match && !cnt_wr) |=> (count == `TMR_BOTTOM) && flags.compare_a_flag)
      else $error("clear on compare a failed");

   fixed_top_a: assert property (
      (tick && ctrl.waveform_mode_select == `TMR_WGM_FPWM8 && count == `TMR_TOP_8 &&
       !block_match && !cnt_wr) |=> (count == `TMR_BOTTOM) && flags.overflow_flag)
      else $error("8-bit fast pwm top not honoured");

   buf_load_a: assert property (
      (pwm && at_top) |=> (cmp_a_act == $past(cmp_a_buf)))
      else $error("compare a buffer not loaded at top");

   tick_hold_a: assert property (
      (!tick && !cnt_wr) |=> $stable(count) && !$rose(flags.overflow_flag))
      else $error("counter moved without a tick");

   mask_b_a: assert property (
      (wr && PADDR == `TMR_REG_CMPB)
      |=> ((cmp_b & ~$past(wmask)) == `TMR_BOTTOM))
      else $error("compare write not masked to resolution");

   pwm_set_a: assert property (
      (pwm && match_b && ctrl.compare_b_output_action == `TMR_ACT_CLEAR)
      |=> oc_b)
      else $error("non-inverting output not set on match");

   force_quiet_a: assert property (
      (force_a && !tick) |=> !$rose(flags.compare_a_flag) && $stable(count))
      else $error("force disturbed flag or counter");

   none_hold_a: assert property (
      (ctrl.compare_a_output_action == `TMR_ACT_NONE && !(wr && PADDR == `TMR_REG_CTRL))
      |=> $stable(oc_a))
      else $error("output moved with no action selected");

   cv_ctc_toggle: cover property (
      ctrl.waveform_mode_select == `TMR_WGM_CTC_A && match_a ##1 $changed(oc_a));
   cv_pwm_top: cover property (pwm && at_top && flags.capture_flag == 1'b0 ##1 flags.capture_flag);
   cv_normal_ovf: cover property (
      ctrl.waveform_mode_select == `TMR_WGM_NORMAL ##0 $rose(flags.overflow_flag));
   cv_force: cover property (force_a ##1 $changed(oc_a));

endmodule

// [shared/tmr_defines.svh]
// register offsets, field codes, fixed tops and reset values of the 16-bit timer
// assumes an apb slave with 32-bit data and byte addresses on word boundaries
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define TMR_ADDR_W 8
`define TMR_REG_CTRL 8'h00
`define TMR_REG_FORCE 8'h04
`define TMR_REG_COUNT 8'h08
`define TMR_REG_CMPA 8'h0c
`define TMR_REG_CMPB 8'h10
`define TMR_REG_CAPTOP 8'h14
`define TMR_REG_FLAGS 8'h18

// ****************************************
// reset values
// ****************************************
`define TMR_RST_WORD 32'h0000_0000
`define TMR_RST_16 16'h0000
`define TMR_RST_FLAGS 4'h0

// ****************************************
// waveform modes
// ****************************************
`define TMR_WGM_NORMAL 4'h0
`define TMR_WGM_CTC_A 4'h4
`define TMR_WGM_FPWM8 4'h5
`define TMR_WGM_FPWM9 4'h6
`define TMR_WGM_FPWM10 4'h7
`define TMR_WGM_CTC_CAP 4'hc
`define TMR_WGM_FPWM_CAP 4'he
`define TMR_WGM_FPWM_A 4'hf

// ****************************************
// counter limits
// ****************************************
`define TMR_BOTTOM 16'h0000
`define TMR_MAX 16'hffff
`define TMR_TOP_8 16'h00ff
`define TMR_TOP_9 16'h01ff
`define TMR_TOP_10 16'h03ff
`define TMR_ONE 16'h0001

// ****************************************
// compare output actions (2/3 are non-inverting/inverting in pwm)
// ****************************************
`define TMR_ACT_NONE 2'h0
`define TMR_ACT_TOGGLE 2'h1
`define TMR_ACT_CLEAR 2'h2
`define TMR_ACT_SET 2'h3

// ****************************************
// clock select and prescaler taps
// ****************************************
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_DIV8_BITS 3
`define TMR_DIV64_BITS 6
`define TMR_DIV256_BITS 8
`define TMR_DIV1024_BITS 10
`define TMR_PRESCALE_W 10

// ****************************************
// flag and strobe bits
// ****************************************
`define TMR_FLAG_OVF 0
`define TMR_FLAG_CMPA 1
`define TMR_FLAG_CMPB 2
`define TMR_FLAG_CAP 3
`define TMR_FORCE_A 0
`define TMR_FORCE_B 1

`endif

// [shared/tmr_pkg.sv]
// types shared by the timer and its bench
// assumes tmr_defines.svh is on the include path
package tmr_pkg;

   // ****************************************
   // control word layout
   // ****************************************
   typedef struct packed {
      logic [18:0] rsvd;
      logic compare_b_pin_direction;
      logic compare_a_pin_direction;
      logic [2:0] clock_select;
      logic [1:0] compare_b_output_action;
      logic [1:0] compare_a_output_action;
      logic [3:0] waveform_mode_select;
   } tmr_ctrl_s;

   // ****************************************
   // sticky event flags
   // ****************************************
   typedef struct packed {
      logic capture_flag;
      logic compare_b_flag;
      logic compare_a_flag;
      logic overflow_flag;
   } tmr_flags_s;

endpackage

// [verif/tmr_timer_test.sv]
// self-checking bench for the 16-bit timer: apb register traffic and compare output waveforms
// assumes tmr_pkg is compiled first and tmr_defines.svh is on the include path
`include "tmr_defines.svh"

module tmr_timer_test
   import tmr_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic oc_a, oe_a_n, oc_b, oe_b_n;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [3:0] flag_ack;
   int failures, comparisons;

   tmr_timer i_dut (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .FLAG_ACK(flag_ack), .OC_A_OUT(oc_a), .OC_A_OE_N(oe_a_n),
      .OC_B_OUT(oc_b), .OC_B_OE_N(oe_b_n));

   always #20 sys_clk = ~sys_clk;

   // ****************************************
   // bus and compare helpers
   // ****************************************
   task automatic tally_and_finish;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdat, exp);
   endtask

   function automatic logic [31:0] ctrl(input logic [3:0] m, input logic [1:0] aa,
         input logic [1:0] ab, input logic [2:0] cs, input logic da, input logic db);
      tmr_ctrl_s c;
      c = tmr_ctrl_s'({19'h0, db, da, cs, ab, aa, m});
      return c;
   endfunction

   // sampled 1 ns after the edge so the outputs have settled
   task automatic cyc(input logic ch, input logic lvl, output int n);
      n = 0;
      #1;
      while ((ch ? oc_b : oc_a) !== lvl && n < 5000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      rd_chk(`TMR_REG_CTRL, `TMR_RST_WORD);
      rd_chk(`TMR_REG_COUNT, `TMR_RST_WORD);
      rd_chk(`TMR_REG_FLAGS, `TMR_RST_WORD);
      check(32'({oc_a, oe_a_n, oc_b, oe_b_n}), 32'h5);
      apb(1'b0, 8'h40, 32'h0);
      check({rdat[30:0], err}, 32'h1);
   endtask

   task automatic t_force;
      wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_NORMAL, `TMR_ACT_CLEAR, 2'h0, `TMR_CS_STOP, 1, 0));
      wr(`TMR_REG_COUNT, 32'h55);
      wr(`TMR_REG_FORCE, 32'h1);
      wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_NORMAL, `TMR_ACT_SET, 2'h0, `TMR_CS_STOP, 1, 0));
      #1;
      check(32'(oc_a), 32'h0);
      wr(`TMR_REG_FORCE, 32'h1);
      #1;
      check(32'({oc_a, oe_a_n}), 32'h2);
      rd_chk(`TMR_REG_FLAGS, 32'h0);
      rd_chk(`TMR_REG_COUNT, 32'h55);
   endtask

   task automatic t_normal;
      wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_NORMAL, 2'h0, 2'h0, `TMR_CS_STOP, 0, 0));
      wr(`TMR_REG_COUNT, 32'hfff0);
      wr(`TMR_REG_FLAGS, 32'hf);
      rd_chk(`TMR_REG_COUNT, 32'hfff0);
      wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_NORMAL, 2'h0, 2'h0, `TMR_CS_DIV1, 0, 0));
      repeat (30) @(posedge sys_clk);
      wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_NORMAL, 2'h0, 2'h0, `TMR_CS_STOP, 0, 0));
      apb(1'b0, `TMR_REG_COUNT, 32'h0);
      check(32'(rdat < 32'h30 && rdat > 32'h10), 32'h1);
      apb(1'b0, `TMR_REG_FLAGS, 32'h0);
      check(32'(rdat[`TMR_FLAG_OVF]), 32'h1);
      flag_ack <= 4'h1;
      @(posedge sys_clk);
      flag_ack <= 4'h0;
      apb(1'b0, `TMR_REG_FLAGS, 32'h0);
      check(32'(rdat[`TMR_FLAG_OVF]), 32'h0);
   endtask

   task automatic t_ctc;
      int divs[5] = '{1, 8, 64, 256, 1024};
      int n;
      for (int i = 0; i < 5; i++) begin
         wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_CTC_A, 2'h0, 2'h0, `TMR_CS_STOP, 1, 0));
         wr(`TMR_REG_COUNT, 32'h0);
         wr(`TMR_REG_CMPA, 32'h1);
         wr(`TMR_REG_FLAGS, 32'hf);
         wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_CTC_A, `TMR_ACT_TOGGLE, 2'h0, 3'(i + 1), 1, 0));
         cyc(0, 1, n);
         cyc(0, 0, n);
         cyc(0, 1, n);
         check(32'(n), 32'(2 * divs[i]));
         check(32'(oe_a_n), 32'h0);
         wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_CTC_A, 2'h0, 2'h0, `TMR_CS_STOP, 1, 0));
         apb(1'b0, `TMR_REG_COUNT, 32'h0);
         check(32'(rdat <= 32'h1), 32'h1);
         apb(1'b0, `TMR_REG_FLAGS, 32'h0);
         check(32'(rdat[`TMR_FLAG_CMPA]), 32'h1);
      end
   endtask

   // count starts above top: it must run through max and wrap before clearing at top
   task automatic t_cap_ctc;
      wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_CTC_CAP, 2'h0, 2'h0, `TMR_CS_STOP, 0, 0));
      wr(`TMR_REG_COUNT, 32'hfff0);
      wr(`TMR_REG_CAPTOP, 32'h3);
      wr(`TMR_REG_FLAGS, 32'hf);
      wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_CTC_CAP, 2'h0, 2'h0, `TMR_CS_DIV1, 0, 0));
      repeat (20) @(posedge sys_clk);
      wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_CTC_CAP, 2'h0, 2'h0, `TMR_CS_STOP, 0, 0));
      apb(1'b0, `TMR_REG_COUNT, 32'h0);
      check(32'(rdat <= 32'h3), 32'h1);
      apb(1'b0, `TMR_REG_FLAGS, 32'h0);
      check(32'({rdat[`TMR_FLAG_CAP], rdat[`TMR_FLAG_OVF]}), 32'h3);
   endtask

   // top 0xff, compare 0xf0: one level lasts 15 ticks, the other 241
   task automatic t_pwm;
      int n;
      for (int act = 2; act < 4; act++) begin
         wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_FPWM8, 2'h0, 2'(act), `TMR_CS_STOP, 0, 1));
         wr(`TMR_REG_COUNT, 32'h0);
         wr(`TMR_REG_CMPB, 32'h12f0);
         rd_chk(`TMR_REG_CMPB, 32'hf0);
         wr(`TMR_REG_FLAGS, 32'hf);
         wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_FPWM8, 2'h0, 2'(act), `TMR_CS_DIV1, 0, 1));
         cyc(1, 0, n);
         cyc(1, 1, n);
         cyc(1, 0, n);
         check(32'(n), (act == 2) ? 32'd15 : 32'd241);
         cyc(1, 1, n);
         check(32'(n), (act == 2) ? 32'd241 : 32'd15);
         check(32'(oe_b_n), 32'h0);
         apb(1'b0, `TMR_REG_FLAGS, 32'h0);
         check(32'({rdat[`TMR_FLAG_CMPB], rdat[`TMR_FLAG_OVF]}), 32'h3);
      end
   endtask

   // compare a as top in fast pwm: each toggle half lasts 1+top ticks
   task automatic t_pwm_a;
      int n;
      wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_NORMAL, 2'h0, 2'h0, `TMR_CS_STOP, 1, 0));
      wr(`TMR_REG_CMPA, 32'h3);
      wr(`TMR_REG_COUNT, 32'h0);
      wr(`TMR_REG_FLAGS, 32'hf);
      wr(`TMR_REG_CTRL, ctrl(`TMR_WGM_FPWM_A, `TMR_ACT_TOGGLE, 2'h0, `TMR_CS_DIV1, 1, 0));
      cyc(0, 1, n);
      cyc(0, 0, n);
      cyc(0, 1, n);
      check(32'(n), 32'h4);
      // written while the count is low: the old top of 3 still ends this period
      wr(`TMR_REG_CMPA, 32'h7);
      cyc(0, 0, n);
      check(32'(n), 32'h1);
      cyc(0, 1, n);
      check(32'(n), 32'h8);
      apb(1'b0, `TMR_REG_FLAGS, 32'h0);
      check(32'(rdat[3:0]), 32'h3);
   endtask

   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, flag_ack} = '0;
      failures = 0;
      comparisons = 0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_force();
      t_normal();
      t_ctc();
      t_cap_ctc();
      t_pwm();
      t_pwm_a();
      tally_and_finish();
   end

   // the divide-by-1024 sweep dominates; about 40000 cycles is ample
   initial begin
      #1_600_000;
      failures++;
      tally_and_finish();
   end
endmodule
